// ==== core/pmsf_pkg.sv ====
// Purpose: shared constants and carrier types for the stream filter config block
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   offsets are byte addresses
`default_nettype none
package pmsf_pkg;
  localparam int unsigned STREAM_TAG_WIDTH = 15;
  localparam int unsigned GROUPS           = 1;
  localparam int unsigned MATCH_MASK_LSB   = 16;
  localparam int unsigned ADDR_W           = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CAP         = 8'h00;
  localparam logic [7:0] OFF_SETUP0      = 8'h04;
  localparam logic [7:0] OFF_MATCH0      = 8'h08;
  // capability field positions
  localparam int unsigned CAP_GRP_LSB      = 24;
  localparam int unsigned CAP_USER_BIT     = 19;
  localparam int unsigned CAP_EXPORT_BIT   = 16;
  localparam int unsigned CAP_PRESCALE_BIT = 15;
  localparam int unsigned CAP_TALLY_BIT    = 14;
  localparam int unsigned CAP_SIZE_LSB   = 11;
  localparam int unsigned CAP_RSV_LSB    = 8;
  localparam int unsigned CAP_N_LSB      = 0;
  localparam logic [1:0] CAP_SIZE_VAL    = 2'h3;
  localparam logic [2:0] CAP_RSV_VAL     = 3'h7;
  localparam logic [7:0] CAP_N_VAL       = 8'h02;
  localparam logic       CAP_EX_RESET    = 1'b1;
  // group setup: filter select field
  localparam int unsigned SETUP_SEL_LSB  = 8;
  localparam logic [1:0] SEL_GLOBAL      = 2'h0;
  localparam logic [1:0] SEL_STREAM      = 2'h1;
  localparam logic [1:0] AXI_OKAY        = 2'h0;
  localparam logic [1:0] AXI_SLVERR      = 2'h2;
  localparam logic [31:0] ZERO32         = 32'h0000_0000;

  typedef struct packed {
    logic [STREAM_TAG_WIDTH-1:0] mask;
    logic [STREAM_TAG_WIDTH-1:0] cmp;
  } pmsf_match_t;
endpackage : pmsf_pkg
`default_nettype wire

// ==== core/pmsf_matcher.sv ====
// Purpose: combinational stream tag comparator for one counter group
// Assumes: tag arrives with its event in the same cycle
// Notes:   mask bit 1 makes the position a don't care
`default_nettype none
module pmsf_matcher (
  input  wire logic                 [pmsf_pkg::STREAM_TAG_WIDTH-1:0] tag_i,
  input  wire pmsf_pkg::pmsf_match_t                                 match_i,
  output logic                                                       hit_o
);
  logic [pmsf_pkg::STREAM_TAG_WIDTH-1:0] bit_ok;
  // per bit: ignored, or equal to compare value
  genvar g;
  generate
    for (g = 0; g < pmsf_pkg::STREAM_TAG_WIDTH; g++)
    begin : g_bit
      assign bit_ok[g] = match_i.mask[g] | (tag_i[g] == match_i.cmp[g]);
    end
  endgenerate
  assign hit_o = &bit_ok;
endmodule : pmsf_matcher
`default_nettype wire

// ==== core/pmsf_gate.sv ====
// Purpose: qualifies one group's event pulse by its filter select
// Assumes: select value 2 is handled by context logic outside
// Notes:   reserved select 3 counts nothing
`default_nettype none
module pmsf_gate (
  input  wire logic [1:0] sel_i,
  input  wire logic       event_i,
  input  wire logic       hit_i,
  output logic            count_o
);
  wire is_glob = (sel_i == pmsf_pkg::SEL_GLOBAL);
  wire is_strm = (sel_i == pmsf_pkg::SEL_STREAM);
  // stream qualification only applies when selected
  assign count_o = event_i & (is_glob | (is_strm & hit_i));
endmodule : pmsf_gate
`default_nettype wire

// ==== core/pmsf_regs.sv ====
// Purpose: stream match and capability registers of the perf monitor, AXI4-Lite slave
// Assumes: one group, synchronous inputs, 125 MHz clock
// Notes:   one write and one read outstanding; answers one cycle after acceptance
//
// How it works
// - a compare bit is skipped when its mask bit is 1 and must equal the tag bit when 0.
// - match bits above the tag width read zero and drop written data.
// - every match register has the same number of compare and mask bits.
// - compare and mask widths both equal the tag width parameter.
// - compare sits from bit 0, mask from bit 16, the rest reserved.
// - stream qualification acts only when the group's filter select enables it.
// - with filter select 01 only events whose tag matches are counted.
// - the group count field in bits 31:24 reports groups minus one, 0 after reset.
// - the user access bit 19 reads 0.
// - the event output bit 16 resets to 1 and accepts writes.
// - the prescale bit 15 reads 0.
// - the cycle tally bit 14 reads 0.
// - the counter width field 12:11 reads 11 for 32-bit counters.
// - the counter count field 7:0 reads 2, counters being value plus one.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`default_nettype none
module pmsf_regs (
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_n_i,
  // axi4-lite write address
  input  wire logic [pmsf_pkg::ADDR_W-1:0]           s_awaddr_i,
  input  wire logic                                  s_awvalid_i,
  output logic                                       s_awready_o,
  // write data
  input  wire logic [31:0]                           s_wdata_i,
  input  wire logic [3:0]                            s_wstrb_i,
  input  wire logic                                  s_wvalid_i,
  output logic                                       s_wready_o,
  // write response
  output logic [1:0]                                 s_bresp_o,
  output logic                                       s_bvalid_o,
  input  wire logic                                  s_bready_i,
  // read address
  input  wire logic [pmsf_pkg::ADDR_W-1:0]           s_araddr_i,
  input  wire logic                                  s_arvalid_i,
  output logic                                       s_arready_o,
  // read data
  output logic [31:0]                                s_rdata_o,
  output logic [1:0]                                 s_rresp_o,
  output logic                                       s_rvalid_o,
  input  wire logic                                  s_rready_i,
  // event path
  input  wire logic                                  event_i,
  input  wire logic [pmsf_pkg::STREAM_TAG_WIDTH-1:0] event_tag_i,
  output logic                                       event_count_o,
  output logic                                       event_output_en_o
);
  localparam int unsigned W = pmsf_pkg::STREAM_TAG_WIDTH;

  // write channel state
  logic                          aw_have_reg;
  logic                          w_have_reg;
  logic [pmsf_pkg::ADDR_W-1:0]   awaddr_reg;
  logic [31:0]                   wdata_reg;
  logic [3:0]                    wstrb_reg;
  logic                          bvalid_reg;
  logic [1:0]                    bresp_reg;
  // read channel state
  logic                          rvalid_reg;
  logic [31:0]                   rdata_reg;
  logic [1:0]                    rresp_reg;
  // register storage
  logic                          export_reg;
  logic [1:0]                    sel_reg;
  logic [7:0]                    setup_low_reg;
  pmsf_pkg::pmsf_match_t         match_reg;
  pmsf_pkg::pmsf_match_t         match_next;
  logic                          hit;

  // handshakes: take the write channels while their holding slot is empty and no response is pending, the read channel while no read data is pending
  assign s_awready_o = ~aw_have_reg & ~bvalid_reg;
  assign s_wready_o  = ~w_have_reg & ~bvalid_reg;
  assign s_arready_o = ~rvalid_reg;
  assign s_bvalid_o  = bvalid_reg;
  assign s_bresp_o   = bresp_reg;
  assign s_rvalid_o  = rvalid_reg;
  assign s_rdata_o   = rdata_reg;
  assign s_rresp_o   = rresp_reg;

  wire aw_fire = s_awvalid_i & s_awready_o;
  wire w_fire  = s_wvalid_i & s_wready_o;
  wire ar_fire = s_arvalid_i & s_arready_o;

  // merged view of address and data, whichever arrived first
  wire                        aw_ok  = aw_have_reg | aw_fire;
  wire                        w_ok   = w_have_reg | w_fire;
  wire [pmsf_pkg::ADDR_W-1:0] wa     = aw_have_reg ? awaddr_reg : s_awaddr_i;
  wire [31:0]                 wd     = w_have_reg ? wdata_reg : s_wdata_i;
  wire [3:0]                  ws     = w_have_reg ? wstrb_reg : s_wstrb_i;
  wire                        do_wr  = aw_ok & w_ok & ~bvalid_reg;

  // write decode
  wire hit_w_cap   = (wa == pmsf_pkg::OFF_CAP);
  wire hit_w_setup = (wa == pmsf_pkg::OFF_SETUP0);
  wire hit_w_match = (wa == pmsf_pkg::OFF_MATCH0);
  wire w_mapped    = hit_w_cap | hit_w_setup | hit_w_match;

  // byte-lane merge of the full word, then trim to implemented fields
  wire [31:0] match_word = {1'b0, match_reg.mask, 1'b0, match_reg.cmp};
  wire [31:0] merged;
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_lane
      assign merged[8*b +: 8] = ws[b] ? wd[8*b +: 8] : match_word[8*b +: 8];
    end
  endgenerate
  // only tag-width bits survive; compare and mask equal width
  assign match_next.cmp  = merged[W-1:0];
  assign match_next.mask = merged[pmsf_pkg::MATCH_MASK_LSB +: W];

  wire export_wr = do_wr & hit_w_cap & ws[pmsf_pkg::CAP_EXPORT_BIT/8];
  wire setup_wr1 = do_wr & hit_w_setup & ws[1];
  wire setup_wr0 = do_wr & hit_w_setup & ws[0];

  // capability word: constants plus the one writable export bit
  wire [31:0] cap_word =
      ({24'h00_0000, pmsf_pkg::CAP_N_VAL} << pmsf_pkg::CAP_N_LSB)
    | ({29'h0000_0000, pmsf_pkg::CAP_RSV_VAL} << pmsf_pkg::CAP_RSV_LSB)
    | ({30'h0000_0000, pmsf_pkg::CAP_SIZE_VAL} << pmsf_pkg::CAP_SIZE_LSB)
    | ({31'h0000_0000, export_reg} << pmsf_pkg::CAP_EXPORT_BIT)
    | ({24'h00_0000, 8'(pmsf_pkg::GROUPS - 1)} << pmsf_pkg::CAP_GRP_LSB);
  // bits 19, 15 and 14 are never set above

  wire [31:0] setup_word = {22'h00_0000, sel_reg, setup_low_reg};

  // read decode
  wire hit_r_cap   = (s_araddr_i == pmsf_pkg::OFF_CAP);
  wire hit_r_setup = (s_araddr_i == pmsf_pkg::OFF_SETUP0);
  wire hit_r_match = (s_araddr_i == pmsf_pkg::OFF_MATCH0);
  wire r_mapped    = hit_r_cap | hit_r_setup | hit_r_match;
  wire [31:0] rd_mux = hit_r_cap ? cap_word :
                       hit_r_setup ? setup_word :
                       hit_r_match ? match_word : pmsf_pkg::ZERO32;

  // write holding slots and response
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= pmsf_pkg::ZERO32;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= pmsf_pkg::AXI_OKAY;
    end
    else
    begin
      if (aw_fire)
        awaddr_reg <= s_awaddr_i;
      if (w_fire)
      begin
        wdata_reg <= s_wdata_i;
        wstrb_reg <= s_wstrb_i;
      end
      aw_have_reg <= do_wr ? 1'b0 : aw_ok;
      w_have_reg  <= do_wr ? 1'b0 : w_ok;
      if (do_wr)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= w_mapped ? pmsf_pkg::AXI_OKAY : pmsf_pkg::AXI_SLVERR;
      end
      else if (s_bready_i)
        bvalid_reg <= 1'b0;
    end
  end

  // register storage updates
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      export_reg    <= pmsf_pkg::CAP_EX_RESET;
      sel_reg       <= pmsf_pkg::SEL_GLOBAL;
      setup_low_reg <= 8'h00;
      match_reg     <= '0;
    end
    else
    begin
      if (export_wr)
        export_reg <= wd[pmsf_pkg::CAP_EXPORT_BIT];
      if (setup_wr1)
        sel_reg <= wd[pmsf_pkg::SETUP_SEL_LSB +: 2];
      if (setup_wr0)
        setup_low_reg <= wd[7:0];
      if (do_wr & hit_w_match)
        match_reg <= match_next;
    end
  end

  // read response, one cycle after the address is taken
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= pmsf_pkg::ZERO32;
      rresp_reg  <= pmsf_pkg::AXI_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= r_mapped ? pmsf_pkg::AXI_OKAY : pmsf_pkg::AXI_SLVERR;
    end
    else if (s_rready_i)
      rvalid_reg <= 1'b0;
  end

  // event qualification path, no register stage so the count is same-cycle
  pmsf_matcher u_matcher (
    .tag_i   (event_tag_i),
    .match_i (match_reg),
    .hit_o   (hit)
  );

  pmsf_gate u_gate (
    .sel_i   (sel_reg),
    .event_i (event_i),
    .hit_i   (hit),
    .count_o (event_count_o)
  );

  assign event_output_en_o = export_reg;

  // checks
  chk_mask_ignores: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (event_i && sel_reg == pmsf_pkg::SEL_STREAM && (((event_tag_i ^ match_reg.cmp)
      & ~match_reg.mask) == '0)) |-> event_count_o)
    else $error("unmasked-equal tag not counted");
  chk_mismatch_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sel_reg == pmsf_pkg::SEL_STREAM && (((event_tag_i ^ match_reg.cmp)
      & ~match_reg.mask) != '0)) |-> !event_count_o)
    else $error("mismatching tag counted");
  chk_global_pass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sel_reg == pmsf_pkg::SEL_GLOBAL) |-> (event_count_o == event_i))
    else $error("global mode did not pass events");

  sequence s_match_rd;
    ar_fire && hit_r_match;
  endsequence
  chk_match_reserved: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_match_rd |=> (rvalid_reg && rdata_reg[15] == 1'b0 && rdata_reg[31] == 1'b0))
    else $error("reserved match bits read nonzero");

  sequence s_cap_rd;
    ar_fire && hit_r_cap;
  endsequence
  chk_cap_fixed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_cap_rd |=> (rdata_reg[31:24] == 8'h00 && rdata_reg[19] == 1'b0 &&
      rdata_reg[15:14] == 2'h0 && rdata_reg[12:11] == 2'h3 && rdata_reg[7:0] == 8'h02))
    else $error("capability constant fields wrong");
  chk_export_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    export_wr |=> (export_reg == $past(wd[16])))
    else $error("export bit write not taken");
  chk_match_width: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (do_wr && hit_w_match && ws == 4'hf) |=>
      (match_reg.cmp == $past(wd[14:0]) && match_reg.mask == $past(wd[30:16])))
    else $error("match fields not stored at their positions");
  chk_read_answer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ar_fire |=> (rvalid_reg && rresp_reg == $past(r_mapped ? pmsf_pkg::AXI_OKAY
      : pmsf_pkg::AXI_SLVERR) && (!$past(hit_r_cap)
      || rdata_reg[12:11] == pmsf_pkg::CAP_SIZE_VAL)))
    else $error("read not answered next cycle with its response");
endmodule : pmsf_regs
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the stream filter config register block
// Assumes: axi4-lite slave answers one cycle after acceptance, one group, tag width 15
// Notes:   tasks speak the bus; event path checked combinationally mid-cycle
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i;
  logic        rst_n_i;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic        ev, ev_cnt, ev_out_en;
  logic [14:0] tag;
  int          errors, total_checks, cycles;
  pmsf_regs uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
    .s_wdata_i(wdata), .s_wstrb_i(wstrb), .s_wvalid_i(wvalid), .s_wready_o(wready),
    .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
    .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
    .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready),
    .event_i(ev), .event_tag_i(tag), .event_count_o(ev_cnt),
    .event_output_en_o(ev_out_en));
  // free-running 125 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // hang guard: the whole sequence needs a few hundred cycles
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic do_reset();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
  endtask : do_reset
  // offers address and data together, releases each once taken, waits for the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
    while (n < 50)
    begin
      @(posedge clk_i);
      n = n + 1;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        resp = bresp;
        bready <= 1'b0;
        n = 100;
      end
    end
    if (n != 100) check("write answer", 32'h0000_0000, 32'h0000_0001);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    d = 32'h0000_0000;
    @(posedge clk_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (n < 50)
    begin
      @(posedge clk_i);
      n = n + 1;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        n = 100;
      end
    end
    if (n != 100) check("read answer", 32'h0000_0000, 32'h0000_0001);
  endtask : rd
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(what, d, exp);
    check("read resp", {30'h0, resp}, {30'h0, pmsf_pkg::AXI_OKAY});
  endtask : rd_chk
  // drives one event and looks at the qualified output mid-cycle
  task automatic ev_chk(input logic e, input logic [14:0] t, input logic exp);
    @(posedge clk_i);
    ev <= e;
    tag <= t;
    @(negedge clk_i);
    check("event count", {31'h0, ev_cnt}, {31'h0, exp});
  endtask : ev_chk
  task automatic set_match(input logic [14:0] m, input logic [14:0] c);
    wr(pmsf_pkg::OFF_MATCH0, {1'b0, m, 1'b0, c}, 4'hf);
  endtask : set_match
  initial
  begin : main
    logic [31:0] d;
    errors = 0; total_checks = 0; cycles = 0; rst_n_i = 1'b0;
    awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0000_0000; wstrb = 4'h0; wvalid = 1'b0;
    bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0; ev = 1'b0; tag = 15'h0000;
    do_reset();
    // capability word after reset
    rd_chk("capability reset", pmsf_pkg::OFF_CAP, 32'h0001_1f02);
    check("export enable", {31'h0, ev_out_en}, 32'h0000_0001);
    // only the export bit takes writes; lane 2 off keeps it
    wr(pmsf_pkg::OFF_CAP, 32'h0000_0000, 4'hb);
    rd_chk("capability lane off", pmsf_pkg::OFF_CAP, 32'h0001_1f02);
    wr(pmsf_pkg::OFF_CAP, 32'h0000_0000, 4'hf);
    rd_chk("capability cleared", pmsf_pkg::OFF_CAP, 32'h0000_1f02);
    check("export enable off", {31'h0, ev_out_en}, 32'h0000_0000);
    wr(pmsf_pkg::OFF_CAP, 32'hffff_ffff, 4'hf);
    rd_chk("capability set", pmsf_pkg::OFF_CAP, 32'h0001_1f02);
    // match register field layout and unimplemented bits
    wr(pmsf_pkg::OFF_MATCH0, 32'hffff_ffff, 4'hf);
    rd_chk("match all ones", pmsf_pkg::OFF_MATCH0, 32'h7fff_7fff);
    wr(pmsf_pkg::OFF_MATCH0, 32'h5555_aaaa, 4'hf);
    rd_chk("match pattern", pmsf_pkg::OFF_MATCH0, 32'h5555_2aaa);
    // unmapped address answers with an error and drops the write
    wr(8'h40, 32'hffff_ffff, 4'hf);
    check("unmapped bresp", {30'h0, resp}, {30'h0, pmsf_pkg::AXI_SLVERR});
    rd(8'h40, d);
    check("unmapped rresp", {30'h0, resp}, {30'h0, pmsf_pkg::AXI_SLVERR});
    check("unmapped rdata", d, 32'h0000_0000);
    // global select counts every event regardless of tag
    wr(pmsf_pkg::OFF_SETUP0, {22'h0, pmsf_pkg::SEL_GLOBAL, 8'h00}, 4'hf);
    set_match(15'h0000, 15'h1234);
    ev_chk(1'b1, 15'h7777, 1'b1);
    ev_chk(1'b0, 15'h1234, 1'b0);
    // stream select: compare with mask
    wr(pmsf_pkg::OFF_SETUP0, {22'h0, pmsf_pkg::SEL_STREAM, 8'h00}, 4'hf);
    set_match(15'h000f, 15'h1234);
    ev_chk(1'b1, 15'h1234, 1'b1);
    ev_chk(1'b1, 15'h123b, 1'b1);
    ev_chk(1'b1, 15'h1334, 1'b0);
    ev_chk(1'b0, 15'h1234, 1'b0);
    // each tag bit alone: masked is ignored, unmasked must equal
    for (int i = 0; i < 15; i++)
    begin
      set_match(15'h0001 << i, 15'h0000);
      ev_chk(1'b1, 15'h0001 << i, 1'b1);
      set_match(15'h0000, 15'h0000);
      ev_chk(1'b1, 15'h0001 << i, 1'b0);
    end
    // context and reserved selects count nothing in this block
    wr(pmsf_pkg::OFF_SETUP0, 32'h0000_0200, 4'hf);
    ev_chk(1'b1, 15'h0000, 1'b0);
    wr(pmsf_pkg::OFF_SETUP0, 32'h0000_0300, 4'hf);
    ev_chk(1'b1, 15'h0000, 1'b0);
    // second reset restores the capability word and the export enable
    wr(pmsf_pkg::OFF_CAP, 32'h0000_0000, 4'hf);
    do_reset();
    rd_chk("capability re-reset", pmsf_pkg::OFF_CAP, 32'h0001_1f02);
    check("export after reset", {31'h0, ev_out_en}, 32'h0000_0001);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
